// File: core/branch_pkg.sv
package branch_pkg;

   typedef enum logic [1:0] {
      ST_STRAP = 2'h0,
      ST_RUN = 2'h1,
      ST_HALT = 2'h2
   } run_state_t;

   typedef enum logic [4:0] {
      C_NO_OPERATION = 5'h00,
      C_SHORT_RELATIVE_BRANCH = 5'h01,
      C_BRANCH_IF_CARRY_SET = 5'h02,
      C_BRANCH_IF_CARRY_CLEAR = 5'h03,
      C_BRANCH_IF_ACC_ZERO = 5'h04,
      C_BRANCH_IF_ACC_NONZERO = 5'h05,
      C_DEC_REG = 5'h06,
      C_LONG_ABSOLUTE_BRANCH = 5'h07,
      C_LONG_SUBROUTINE_CALL = 5'h08,
      C_BRANCH_IF_BIT_SET = 5'h09,
      C_BRANCH_IF_BIT_CLEAR = 5'h0a,
      C_BRANCH_BIT_SET_AND_CLEAR = 5'h0b,
      C_CMP_ACC_DIRECT = 5'h0c,
      C_CMP_ACC_IMM = 5'h0d,
      C_CMP_REG_IMM = 5'h0e,
      C_CMP_IND_IMM = 5'h0f,
      C_DEC_DIRECT = 5'h10,
      C_XRD = 5'h11,
      C_XWR = 5'h12,
      C_ILLEGAL = 5'h13,
      C_IRQ = 5'h14
   } op_class_t;

   localparam logic [7:0] OP_NO_OPERATION = 8'h00;
   localparam logic [7:0] OP_LONG_BRANCH = 8'h02;
   localparam logic [7:0] OP_BIT_SET_AND_CLEAR = 8'h10;
   localparam logic [7:0] OP_LONG_CALL = 8'h12;
   localparam logic [7:0] OP_BIT_SET = 8'h20;
   localparam logic [7:0] OP_BIT_CLEAR = 8'h30;
   localparam logic [7:0] OP_CARRY_SET = 8'h40;
   localparam logic [7:0] OP_CARRY_CLEAR = 8'h50;
   localparam logic [7:0] OP_ACC_ZERO = 8'h60;
   localparam logic [7:0] OP_ACC_NONZERO = 8'h70;
   localparam logic [7:0] OP_SHORT_BRANCH = 8'h80;
   localparam logic [7:0] OP_CMP_ACC_IMM = 8'hb4;
   localparam logic [7:0] OP_CMP_ACC_DIRECT = 8'hb5;
   localparam logic [7:0] OP_DEC_DIRECT = 8'hd5;
   localparam logic [7:0] OP_XRD_DPTR = 8'he0;
   localparam logic [7:0] OP_XWR_DPTR = 8'hf0;

   localparam logic [3:0] CYC_NO_OPERATION = 4'h1;
   localparam logic [3:0] CYC_SHORT = 4'h3;
   localparam logic [3:0] CYC_LONG = 4'h4;
   localparam logic [3:0] CYC_IRQ_CALL = 4'h3;
   localparam logic [3:0] CYC_XMOVE_BASE = 4'h4;

   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;

   function automatic op_class_t decode(input logic [7:0] op);
      casez (op)
         OP_NO_OPERATION: return C_NO_OPERATION;
         OP_SHORT_BRANCH: return C_SHORT_RELATIVE_BRANCH;
         OP_CARRY_SET: return C_BRANCH_IF_CARRY_SET;
         OP_CARRY_CLEAR: return C_BRANCH_IF_CARRY_CLEAR;
         OP_ACC_ZERO: return C_BRANCH_IF_ACC_ZERO;
         OP_ACC_NONZERO: return C_BRANCH_IF_ACC_NONZERO;
         8'b11011???: return C_DEC_REG;
         OP_LONG_BRANCH: return C_LONG_ABSOLUTE_BRANCH;
         OP_LONG_CALL: return C_LONG_SUBROUTINE_CALL;
         OP_BIT_SET: return C_BRANCH_IF_BIT_SET;
         OP_BIT_CLEAR: return C_BRANCH_IF_BIT_CLEAR;
         OP_BIT_SET_AND_CLEAR: return C_BRANCH_BIT_SET_AND_CLEAR;
         OP_CMP_ACC_DIRECT: return C_CMP_ACC_DIRECT;
         OP_CMP_ACC_IMM: return C_CMP_ACC_IMM;
         8'b10111???: return C_CMP_REG_IMM;
         8'b1011011?: return C_CMP_IND_IMM;
         OP_DEC_DIRECT: return C_DEC_DIRECT;
         OP_XRD_DPTR, 8'b1110001?: return C_XRD;
         OP_XWR_DPTR, 8'b1111001?: return C_XWR;
         default: return C_ILLEGAL;
      endcase
   endfunction

   function automatic logic [1:0] byte_count(input op_class_t c);
      case (c)
         C_NO_OPERATION, C_ILLEGAL, C_XRD, C_XWR: return 2'h1;
         C_SHORT_RELATIVE_BRANCH, C_BRANCH_IF_CARRY_SET, C_BRANCH_IF_CARRY_CLEAR,
         C_BRANCH_IF_ACC_ZERO, C_BRANCH_IF_ACC_NONZERO, C_DEC_REG: return 2'h2;
         C_IRQ: return 2'h0;
         default: return 2'h3;
      endcase
   endfunction

   function automatic logic is_relative(input op_class_t c);
      return !(c inside {C_NO_OPERATION, C_ILLEGAL, C_XRD, C_XWR, C_IRQ,
                         C_LONG_ABSOLUTE_BRANCH, C_LONG_SUBROUTINE_CALL});
   endfunction

endpackage

// File: core/rel_target.sv
module rel_target (
   input wire logic [15:0] base,
   input wire logic [7:0] offset,
   output logic [15:0] target
);
   // sign extension keeps backward branches within the 16-bit wrap
   assign target = base + {{8{offset[7]}}, offset};
endmodule

// File: core/branch_instruction_timing.sv
// What this block does
// - The short relative branch is two bytes and always takes three clocks.
// - Branch on accumulator zero or nonzero are two bytes and take three clocks each.
// - Decrement a working register and branch if nonzero is two bytes and three clocks.
// - The long absolute branch is three bytes and takes four clocks.
// - The long call is three bytes and four clocks, but three clocks on interrupt entry.
// - Branch on a direct bit set or clear is three bytes and four clocks.
// - Branch on a direct bit set also clears that bit, in three bytes and four clocks.
// - Every compare-and-branch-if-unequal form is three bytes and four clocks.
// - Decrement a direct byte and branch if nonzero is three bytes and four clocks.
// - One cycle is one clock, and the no-operation is one byte and one clock.
// - External data moves take four clocks plus the configured wait-state count.
// - With the external-access pin high at reset the core fetches internal code.
// - Fetch never leaves internal code space, since no external code space exists.
module branch_instruction_timing #(
   parameter int PROG_BYTES = 63488,
   parameter int WAIT_BITS = 3
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic external_access_pin,
   input wire logic [7:0] code_data,
   input wire logic [7:0] data_rdata,
   input wire logic [7:0] acc_value,
   input wire logic carry_flag,
   input wire logic [1:0] reg_bank,
   input wire logic [15:0] dptr_value,
   input wire logic [7:0] xdata_page,
   input wire logic [7:0] xdata_rdata,
   input wire logic [WAIT_BITS-1:0] external_wait_state_count,
   input wire logic irq_req,
   input wire logic [15:0] irq_vector,
   output logic [15:0] code_addr,
   output logic code_rd,
   output logic [7:0] data_addr,
   output logic data_wr,
   output logic [7:0] data_wdata,
   output logic [15:0] xdata_addr,
   output logic xdata_rd,
   output logic xdata_wr,
   output logic [7:0] xdata_wdata,
   output logic acc_wr,
   output logic [7:0] acc_wdata,
   output logic cy_wr,
   output logic cy_wdata,
   output logic irq_ack,
   output logic instr_done,
   output logic illegal_op,
   output logic code_fault
);
   if (PROG_BYTES < 1 || PROG_BYTES > 65536 || WAIT_BITS < 1 || WAIT_BITS > 3) begin : g_chk
      $error("branch_instruction_timing: unsupported parameter values");
   end

   branch_pkg::run_state_t state_q, state_d;
   branch_pkg::op_class_t cls_q, cls_d, cls;
   logic [3:0] cyc_q, cyc_d, last_q, last;
   logic [7:0] op_q, op_d, op1_q, op1_d, rel_q, rel_d, sp_q, sp_d;
   logic take_q, take_d, fetch, cmp_en, bitv;
   logic [7:0] cmp_a, cmp_b, rn_addr, ri_addr;
   logic [15:0] pc_q, pc_d, rel_pc;
   logic [7:0] daddr_d, dwdata_d, xwdata_d, accw_d;
   logic dwr_d, xrd_d, xwr_d, accwr_d, cywr_d, cyv_d, ack_d, done_d, ill_d, fault_d;
   logic [15:0] xaddr_d;

   rel_target u_rel (
      .base(pc_q),
      .offset(rel_q),
      .target(rel_pc)
   );

   always_comb begin
      cls = (cyc_q == 4'h0) ? (irq_req ? branch_pkg::C_IRQ : branch_pkg::decode(code_data))
                            : cls_q;
      case (cls)
         branch_pkg::C_NO_OPERATION, branch_pkg::C_ILLEGAL:
            last = branch_pkg::CYC_NO_OPERATION - 4'h1;
         branch_pkg::C_SHORT_RELATIVE_BRANCH, branch_pkg::C_BRANCH_IF_CARRY_SET,
         branch_pkg::C_BRANCH_IF_CARRY_CLEAR, branch_pkg::C_BRANCH_IF_ACC_ZERO,
         branch_pkg::C_BRANCH_IF_ACC_NONZERO, branch_pkg::C_DEC_REG:
            last = branch_pkg::CYC_SHORT - 4'h1;
         branch_pkg::C_IRQ: last = branch_pkg::CYC_IRQ_CALL - 4'h1;
         branch_pkg::C_XRD, branch_pkg::C_XWR:
            last = branch_pkg::CYC_XMOVE_BASE - 4'h1 + 4'(external_wait_state_count);
         default: last = branch_pkg::CYC_LONG - 4'h1;
      endcase
      if (cyc_q != 4'h0) last = last_q;
      op_d = (cyc_q == 4'h0) ? code_data : op_q;
      rn_addr = {3'h0, reg_bank, op_d[2:0]};
      ri_addr = {3'h0, reg_bank, 2'h0, op_d[0]};
      state_d = state_q;
      cls_d = cls;
      cyc_d = (cyc_q == last) ? 4'h0 : cyc_q + 4'h1;
      pc_d = pc_q;
      op1_d = op1_q;
      rel_d = rel_q;
      sp_d = sp_q;
      take_d = take_q;
      daddr_d = data_addr;
      dwr_d = 1'b0;
      dwdata_d = data_wdata;
      xaddr_d = xdata_addr;
      xrd_d = xdata_rd;
      xwr_d = xdata_wr;
      xwdata_d = xdata_wdata;
      accwr_d = 1'b0;
      accw_d = acc_wdata;
      cywr_d = 1'b0;
      cyv_d = cy_wdata;
      ack_d = 1'b0;
      done_d = 1'b0;
      ill_d = 1'b0;
      fault_d = code_fault;
      cmp_en = 1'b0;
      cmp_a = acc_value;
      cmp_b = code_data;
      bitv = data_rdata[op1_q[2:0]];
      fetch = {2'h0, cyc_q} < {2'h0, branch_pkg::byte_count(cls)};
      if (fetch) pc_d = pc_q + 16'h1;
      if (fetch && cyc_q == {2'h0, branch_pkg::byte_count(cls)} - 4'h1 && cyc_q != 4'h0)
         rel_d = code_data;
      case (cls)
         branch_pkg::C_SHORT_RELATIVE_BRANCH: take_d = 1'b1;
         branch_pkg::C_BRANCH_IF_CARRY_SET: take_d = carry_flag;
         branch_pkg::C_BRANCH_IF_CARRY_CLEAR: take_d = !carry_flag;
         branch_pkg::C_BRANCH_IF_ACC_ZERO: take_d = (acc_value == 8'h00);
         branch_pkg::C_BRANCH_IF_ACC_NONZERO: take_d = (acc_value != 8'h00);
         branch_pkg::C_DEC_REG, branch_pkg::C_DEC_DIRECT: begin
            if (cyc_q == 4'h0 && cls == branch_pkg::C_DEC_REG) daddr_d = rn_addr;
            if (cyc_q == 4'h1 && cls == branch_pkg::C_DEC_DIRECT) daddr_d = code_data;
            // register form reads one cycle earlier since its operand needs no fetch
            if (cyc_q == ((cls == branch_pkg::C_DEC_REG) ? 4'h1 : 4'h2)) begin
               dwr_d = 1'b1;
               dwdata_d = data_rdata - 8'h01;
               take_d = (data_rdata != 8'h01);
            end
         end
         branch_pkg::C_BRANCH_IF_BIT_SET, branch_pkg::C_BRANCH_IF_BIT_CLEAR,
         branch_pkg::C_BRANCH_BIT_SET_AND_CLEAR: begin
            if (cyc_q == 4'h1) begin
               op1_d = code_data;
               daddr_d = code_data[7] ? {code_data[7:3], 3'h0}
                                      : branch_pkg::BIT_AREA_BASE + {4'h0, code_data[6:3]};
            end
            if (cyc_q == 4'h2) begin
               take_d = (cls == branch_pkg::C_BRANCH_IF_BIT_CLEAR) ? !bitv : bitv;
               if (cls == branch_pkg::C_BRANCH_BIT_SET_AND_CLEAR && bitv) begin
                  dwr_d = 1'b1;
                  dwdata_d = data_rdata & ~(8'h01 << op1_q[2:0]);
               end
            end
         end
         branch_pkg::C_CMP_ACC_DIRECT: begin
            if (cyc_q == 4'h1) daddr_d = code_data;
            cmp_en = (cyc_q == 4'h2);
            cmp_b = data_rdata;
         end
         branch_pkg::C_CMP_ACC_IMM: cmp_en = (cyc_q == 4'h1);
         branch_pkg::C_CMP_REG_IMM: begin
            if (cyc_q == 4'h0) daddr_d = rn_addr;
            cmp_en = (cyc_q == 4'h1);
            cmp_a = data_rdata;
         end
         branch_pkg::C_CMP_IND_IMM: begin
            if (cyc_q == 4'h0) daddr_d = ri_addr;
            if (cyc_q == 4'h1) begin
               op1_d = code_data;
               daddr_d = data_rdata;
            end
            cmp_en = (cyc_q == 4'h2);
            cmp_a = data_rdata;
            cmp_b = op1_q;
         end
         branch_pkg::C_LONG_ABSOLUTE_BRANCH, branch_pkg::C_LONG_SUBROUTINE_CALL: begin
            if (cyc_q == 4'h1) op1_d = code_data;
            if (cls == branch_pkg::C_LONG_SUBROUTINE_CALL && cyc_q >= 4'h2) begin
               sp_d = sp_q + 8'h01;
               daddr_d = sp_q + 8'h01;
               dwr_d = 1'b1;
               dwdata_d = (cyc_q == 4'h2) ? pc_d[7:0] : pc_q[15:8];
            end
            if (cyc_q == 4'h3) pc_d = {op1_q, rel_q};
         end
         branch_pkg::C_IRQ: begin
            if (cyc_q <= 4'h1) begin
               sp_d = sp_q + 8'h01;
               daddr_d = sp_q + 8'h01;
               dwr_d = 1'b1;
               dwdata_d = (cyc_q == 4'h0) ? pc_q[7:0] : pc_q[15:8];
            end else begin
               pc_d = irq_vector;
               ack_d = 1'b1;
            end
         end
         branch_pkg::C_XRD, branch_pkg::C_XWR: begin
            if (cyc_q == 4'h0) daddr_d = ri_addr;
            if (cyc_q == 4'h1) begin
               xaddr_d = (op_q[1] == 1'b0) ? dptr_value : {xdata_page, data_rdata};
               xrd_d = (cls == branch_pkg::C_XRD);
               xwr_d = (cls == branch_pkg::C_XWR);
               xwdata_d = acc_value;
            end
            // strobe spans 1 + wait cycles; read data is taken on its last cycle
            if (cyc_q == last - 4'h1) begin
               xrd_d = 1'b0;
               xwr_d = 1'b0;
               accwr_d = (cls == branch_pkg::C_XRD);
               if (cls == branch_pkg::C_XRD) accw_d = xdata_rdata;
            end
         end
         branch_pkg::C_ILLEGAL: ill_d = 1'b1;
         default: ;
      endcase
      if (cmp_en) begin
         take_d = (cmp_a != cmp_b);
         cywr_d = 1'b1;
         cyv_d = (cmp_a < cmp_b);
      end
      if (cyc_q == last) begin
         done_d = 1'b1;
         if (branch_pkg::is_relative(cls) && take_q) pc_d = rel_pc;
      end
      // out-of-range fetch stops the core instead of wrapping outward
      if (fetch && {1'b0, pc_q} >= 17'(PROG_BYTES)) begin
         state_d = branch_pkg::ST_HALT;
         fault_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= branch_pkg::ST_STRAP;
         code_rd <= 1'b0;
      end else begin
         case (state_q)
            branch_pkg::ST_STRAP: begin
               state_q <= external_access_pin ? branch_pkg::ST_RUN : branch_pkg::ST_HALT;
               code_rd <= external_access_pin;
            end
            branch_pkg::ST_RUN: begin
               state_q <= state_d;
               code_rd <= (state_d == branch_pkg::ST_RUN);
            end
            default: code_rd <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cyc_q <= 4'h0;
         last_q <= 4'h0;
         cls_q <= branch_pkg::C_NO_OPERATION;
         op_q <= 8'h00;
         op1_q <= 8'h00;
         rel_q <= 8'h00;
         take_q <= 1'b0;
         pc_q <= branch_pkg::PC_RESET;
         sp_q <= branch_pkg::SP_RESET;
      end else if (state_q == branch_pkg::ST_RUN && state_d == branch_pkg::ST_RUN) begin
         cyc_q <= cyc_d;
         last_q <= last;
         cls_q <= cls_d;
         op_q <= op_d;
         op1_q <= op1_d;
         rel_q <= rel_d;
         take_q <= take_d;
         pc_q <= pc_d;
         sp_q <= sp_d;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         data_addr <= 8'h00;
         data_wr <= 1'b0;
         data_wdata <= 8'h00;
         xdata_addr <= 16'h0000;
         xdata_rd <= 1'b0;
         xdata_wr <= 1'b0;
         xdata_wdata <= 8'h00;
         acc_wr <= 1'b0;
         acc_wdata <= 8'h00;
         cy_wr <= 1'b0;
         cy_wdata <= 1'b0;
         irq_ack <= 1'b0;
         instr_done <= 1'b0;
         illegal_op <= 1'b0;
         code_fault <= 1'b0;
      end else if (state_q == branch_pkg::ST_RUN && state_d == branch_pkg::ST_RUN) begin
         data_addr <= daddr_d;
         data_wr <= dwr_d;
         data_wdata <= dwdata_d;
         xdata_addr <= xaddr_d;
         xdata_rd <= xrd_d;
         xdata_wr <= xwr_d;
         xdata_wdata <= xwdata_d;
         acc_wr <= accwr_d;
         acc_wdata <= accw_d;
         cy_wr <= cywr_d;
         cy_wdata <= cyv_d;
         irq_ack <= ack_d;
         instr_done <= done_d;
         illegal_op <= ill_d;
      end else begin
         data_wr <= 1'b0;
         xdata_rd <= 1'b0;
         xdata_wr <= 1'b0;
         acc_wr <= 1'b0;
         cy_wr <= 1'b0;
         irq_ack <= 1'b0;
         instr_done <= 1'b0;
         illegal_op <= 1'b0;
         code_fault <= fault_d && state_q == branch_pkg::ST_RUN || code_fault;
      end
   end

   assign code_addr = pc_q;

   logic [3:0] strobe_len_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) strobe_len_q <= 4'h0;
      else strobe_len_q <= xdata_rd ? strobe_len_q + 4'h1 : 4'h0;
   end

   logic run_start;
   assign run_start = state_q == branch_pkg::ST_RUN && state_d == branch_pkg::ST_RUN
                      && cyc_q == 4'h0;

   sequence s_start(branch_pkg::op_class_t c);
      run_start && cls == c;
   endsequence

   AST_NO_OP_ONE_CLOCK: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_NO_OPERATION) |=> cyc_q == 4'h0 && pc_q == $past(pc_q) + 16'h1)
      else $error("no-operation did not take one byte and one clock");
   AST_SHORT_BRANCH: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_SHORT_RELATIVE_BRANCH) |-> ##3 cyc_q == 4'h0 &&
      pc_q == $past(pc_q, 3) + 16'h2 + {{8{$past(code_data[7], 2)}}, $past(code_data, 2)})
      else $error("short branch target or length wrong");
   AST_CARRY_BRANCH: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_BRANCH_IF_CARRY_SET) |=> (cyc_q != 4'h0) [*2] ##1 cyc_q == 4'h0)
      else $error("carry branch not three clocks");
   AST_ACC_BRANCH: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_BRANCH_IF_ACC_ZERO) ##1 (acc_value != 8'h00) |->
      ##2 pc_q == $past(pc_q, 3) + 16'h2)
      else $error("zero branch taken with nonzero accumulator");
   AST_DEC_REG: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_DEC_REG) |-> ##2 data_wr && data_wdata == $past(data_rdata) - 8'h01)
      else $error("register decrement not written");
   AST_LONG_BRANCH: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_LONG_ABSOLUTE_BRANCH) |-> ##4 cyc_q == 4'h0 &&
      pc_q == {$past(code_data, 3), $past(code_data, 2)})
      else $error("long branch target or length wrong");
   AST_IRQ_CALL: assert property (@(posedge clock) disable iff (!reset_n)
      s_start(branch_pkg::C_IRQ) |-> ##3 irq_ack && cyc_q == 4'h0 && pc_q == $past(irq_vector))
      else $error("interrupt call not three clocks");
   AST_XMOVE_WAIT: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(xdata_rd) && state_q == branch_pkg::ST_RUN |->
      strobe_len_q == 4'(external_wait_state_count) + 4'h1)
      else $error("external read strobe length wrong");
   AST_STRAP_LOW: assert property (@(posedge clock) disable iff (!reset_n)
      state_q == branch_pkg::ST_STRAP && !external_access_pin |=> !code_rd [*2])
      else $error("fetch started with external-access pin low");
   AST_NO_ROLLOVER: assert property (@(posedge clock) disable iff (!reset_n)
      code_rd && {1'b0, code_addr} >= 17'(PROG_BYTES) |=> !code_rd && code_fault)
      else $error("fetch continued past internal code space");
endmodule

// File: verif/mem_model.sv
module mem_model (
   input wire logic clock,
   input wire logic [15:0] code_addr,
   input wire logic code_rd,
   output logic [7:0] code_data,
   input wire logic [7:0] data_addr,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   output logic [7:0] data_rdata,
   input wire logic [15:0] xdata_addr,
   input wire logic xdata_rd,
   input wire logic xdata_wr,
   input wire logic [7:0] xdata_wdata,
   output logic [7:0] xdata_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] code [256];
   logic [7:0] iram [256];
   logic [7:0] xram [256];
   logic [7:0] junk_q = 8'h5a;
   // idle code and xdata read buses toggle every cycle so a stale byte cannot pass for data
   assign code_data = code_rd ? code[code_addr[7:0]] : junk_q;
   assign data_rdata = iram[data_addr];
   assign xdata_rdata = xdata_rd ? xram[xdata_addr[7:0]] : ~junk_q;
   always @(posedge clock) begin
      junk_q <= ~junk_q;
      if (data_wr === 1'b1) iram[data_addr] <= data_wdata;
      if (xdata_wr === 1'b1) xram[xdata_addr[7:0]] <= xdata_wdata;
   end
endmodule

// File: verif/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 256;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic external_access_pin = 1'b1;
   logic [7:0] acc_value = 8'h00;
   logic carry_flag = 1'b1;
   logic [1:0] reg_bank = 2'h2;
   logic [15:0] dptr_value = 16'h0000;
   logic [7:0] xdata_page = 8'h00;
   logic [2:0] wait_n = 3'h0;
   logic irq_req = 1'b0;
   logic [15:0] irq_vector = 16'h00b0;
   logic [15:0] code_addr, xdata_addr;
   logic [7:0] code_data, data_rdata, xdata_rdata, data_addr, data_wdata, xdata_wdata;
   logic [7:0] acc_wdata;
   logic code_rd, data_wr, xdata_rd, xdata_wr, acc_wr, cy_wr, cy_wdata, irq_ack;
   logic instr_done, illegal_op, code_fault;
   logic [7:0] acc_seen = 8'h00;
   logic cy_seen = 1'b0;
   int num_errors = 0;
   int num_checks = 0;

   always #5 clock = ~clock;
   always @(posedge clock) if (acc_wr === 1'b1) acc_seen <= acc_wdata;
   always @(posedge clock) if (cy_wr === 1'b1) cy_seen <= cy_wdata;

   branch_instruction_timing #(.PROG_BYTES(PROG), .WAIT_BITS(3)) uut (
      .clock, .reset_n, .external_access_pin, .code_data, .data_rdata, .acc_value,
      .carry_flag, .reg_bank, .dptr_value, .xdata_page, .xdata_rdata,
      .external_wait_state_count(wait_n), .irq_req, .irq_vector, .code_addr, .code_rd,
      .data_addr, .data_wr, .data_wdata, .xdata_addr, .xdata_rd, .xdata_wr, .xdata_wdata,
      .acc_wr, .acc_wdata, .cy_wr, .cy_wdata, .irq_ack, .instr_done, .illegal_op,
      .code_fault);

   mem_model mem (.clock, .code_addr, .code_rd, .code_data, .data_addr, .data_wr,
      .data_wdata, .data_rdata, .xdata_addr, .xdata_rd, .xdata_wr, .xdata_wdata, .xdata_rdata);

   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic ram(input string what, input logic [7:0] a, input logic [7:0] exp);
      chk(what, {8'h00, exp}, {8'h00, mem.iram[a]});
   endtask

   task automatic put(input logic [7:0] a, input logic [7:0] b0, b1, b2);
      mem.code[a] = b0;
      mem.code[a + 8'h01] = b1;
      mem.code[a + 8'h02] = b2;
   endtask

   // clocks from one instruction start to the next, then the address reached
   task automatic step(input int cyc, input logic [15:0] pc);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (instr_done !== 1'b1 && n < 20);
      chk("cycles", cyc[15:0], n[15:0]);
      chk("code_addr", pc, code_addr);
   endtask

   task automatic do_reset(input logic pin);
      int n;
      reset_n = 1'b0;
      external_access_pin = pin;
      repeat (2) @(posedge clock);
      #1 reset_n = 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (code_rd !== 1'b1 && n < 8);
   endtask

   task automatic t_relative;
      step(1, 16'h0001);
      step(3, 16'h0005);
      step(3, 16'h0008);
      step(3, 16'h000a);
      acc_value = 8'h01;
      step(3, 16'h000c);
      acc_value = 8'h00;
      step(1, 16'h000d);
      step(1, 16'h000e);
      step(3, 16'h0010);
      step(3, 16'h0022);
      step(3, 16'h0014);
      $display("test relative done");
   endtask

   task automatic t_decrement_branch_nonzero;
      step(3, 16'h0019);
      ram("r1", 8'h11, 8'h04);
      step(3, 16'h001b);
      ram("r2", 8'h12, 8'h00);
      step(4, 16'h0040);
      step(4, 16'h0060);
      ram("push lo", 8'h08, 8'h43);
      ram("push hi", 8'h09, 8'h00);
      $display("test decrement_branch_nonzero and long done");
   endtask

   task automatic t_bits;
      step(4, 16'h0065);
      step(4, 16'h0068);
      step(4, 16'h006d);
      ram("bit byte", 8'h21, 8'h00);
      step(4, 16'h0071);
      step(4, 16'h0074);
      step(4, 16'h0079);
      chk_bit("carry below", 1'b1, cy_seen);
      step(4, 16'h007c);
      chk_bit("carry equal", 1'b0, cy_seen);
      step(4, 16'h0080);
      step(4, 16'h0085);
      ram("direct", 8'h31, 8'h01);
      $display("test bits and compare done");
   endtask

   task automatic t_xmove;
      dptr_value = 16'h0155;
      step(1, 16'h0086);
      step(4, 16'h0087);
      chk("xdata_addr", 16'h0155, xdata_addr);
      chk("acc load", 16'h00a5, {8'h00, acc_seen});
      // wait count changes only while a no-op runs, never inside a move
      wait_n = 3'h3;
      step(1, 16'h0088);
      step(7, 16'h0089);
      chk("xram", 16'h0000, {8'h00, mem.xram[8'h55]});
      $display("test xmove done");
   endtask

   task automatic t_irq;
      int n;
      n = 0;
      irq_req = 1'b1;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (irq_ack !== 1'b1 && n < 20);
      irq_req = 1'b0;
      chk("irq cycles", 16'h0003, n[15:0]);
      chk("vector", 16'h00b0, code_addr);
      ram("irq push", 8'h0a, 8'h89);
      step(1, 16'h00b1);
      chk_bit("illegal_op", 1'b1, illegal_op);
      $display("test irq done");
   endtask

   task automatic t_fault;
      step(4, 16'h00fc);
      step(1, 16'h00fd);
      step(1, 16'h00fe);
      step(1, 16'h00ff);
      repeat (4) @(posedge clock);
      #1;
      chk_bit("code_fault", 1'b1, code_fault);
      chk_bit("fetch stopped", 1'b1, code_addr <= 16'h0100);
      do_reset(1'b0);
      chk_bit("strap low code_rd", 1'b0, code_rd);
      chk("strap low code_addr", 16'h0000, code_addr);
      $display("test fault and strap done");
   endtask

   initial begin
      for (int i = 0; i < 256; i++) begin
         mem.code[i] = 8'h00;
         mem.iram[i] = 8'h00;
         mem.xram[i] = 8'h00;
      end
      mem.iram[8'h10] = 8'h40;
      mem.iram[8'h11] = 8'h05;
      mem.iram[8'h12] = 8'h01;
      mem.iram[8'h13] = 8'h07;
      mem.iram[8'h40] = 8'h09;
      mem.iram[8'h21] = 8'h01;
      mem.iram[8'h30] = 8'h01;
      mem.iram[8'h31] = 8'h02;
      mem.xram[8'h55] = 8'ha5;
      put(8'h01, 8'h80, 8'h02, 8'h00);
      put(8'h05, 8'h40, 8'h01, 8'h00);
      put(8'h08, 8'h50, 8'h7f, 8'h00);
      put(8'h0a, 8'h60, 8'h02, 8'h00);
      put(8'h0e, 8'h70, 8'h05, 8'h00);
      put(8'h10, 8'h80, 8'h10, 8'h00);
      put(8'h14, 8'hd9, 8'h03, 8'h00);
      put(8'h19, 8'hda, 8'h7f, 8'h00);
      put(8'h1b, 8'h02, 8'h00, 8'h40);
      put(8'h22, 8'h80, 8'hf0, 8'h00);
      put(8'h40, 8'h12, 8'h00, 8'h60);
      put(8'h60, 8'h20, 8'h08, 8'h02);
      put(8'h65, 8'h30, 8'h08, 8'h7f);
      put(8'h68, 8'h10, 8'h08, 8'h02);
      put(8'h6d, 8'h30, 8'h08, 8'h01);
      put(8'h71, 8'hb4, 8'h00, 8'h05);
      put(8'h74, 8'hb5, 8'h30, 8'h02);
      put(8'h79, 8'hbb, 8'h07, 8'h01);
      put(8'h7c, 8'hb6, 8'h05, 8'h01);
      put(8'h80, 8'hd5, 8'h31, 8'h02);
      put(8'h86, 8'he0, 8'h00, 8'hf0);
      put(8'hb1, 8'h02, 8'h00, 8'hfc);
      mem.code[8'hb0] = 8'ha5;
      do_reset(1'b1);
      chk_bit("code_rd", 1'b1, code_rd);
      chk("first fetch", 16'h0000, code_addr);
      t_relative;
      t_decrement_branch_nonzero;
      t_bits;
      t_xmove;
      t_irq;
      t_fault;
      test_done;
   end

   initial begin
      #50000;
      num_errors++;
      $display("FAIL watchdog expected done seen timeout");
      test_done;
   end
endmodule
